// file: hw/memref_pkg.sv
// Shared constants, address decode and word packing for the memory reference link
package memref_pkg;
  localparam int ADDR_W      = 35;  // Reference address width
  localparam int SEC_LSB     = 0;   // Section select 2:0
  localparam int SEC_W       = 3;
  localparam int SUB_LSB     = 3;   // Subsection select 5:3
  localparam int SUB_W       = 3;
  localparam int BANK_LSB    = 6;   // Bank select 9:6
  localparam int BANK_W      = 4;
  localparam int WSEL_LSB    = 10;  // Word select 30:10, bits 34:31 unused
  localparam int WSEL_W      = 21;
  localparam int CODE_W      = 4;   // Reference type code
  localparam int TAG_W       = 16;  // Return tag carried in the first packet
  localparam int PKT_W       = 38;  // One write packet
  localparam int WORD_W      = 76;  // Full word, 64 data and 12 check bits
  localparam int HALF_W      = 38;  // One half-word path
  localparam int DATA_CHIPS  = 16;  // Chips holding data pairs per quarter-stack
  localparam int CHIPS       = 19;  // Data and check chips per quarter-stack
  localparam int SPARE_CHIP  = 19;  // Spare chip number (octal 23)
  localparam int CHIP_W      = 5;
  localparam int PHYS_W      = 40;  // 20 chips of 2 bits
  localparam int PAIR_DIST   = 16;  // Data bits paired on one chip
  localparam int CHECK_DIST  = 3;   // Check bits paired on one chip
  localparam int UPPER_OFS   = 32;  // First data bit of the upper path
  localparam int CHECK_LO    = 64;  // First check bit of the lower path
  localparam int CHECK_HI    = 70;  // First check bit of the upper path
  localparam int IN_BUFFERS  = 6;   // Receive buffers, the credit limit
  localparam int CNT_W       = 3;
  localparam int RET_DEPTH   = 8;   // Read return buffer depth

  // Word bit held by path u, chip c, chip bit b
  function automatic int bit_idx(input int u, input int c, input int b);
    if (c < DATA_CHIPS) begin
      bit_idx = (u != 0 ? UPPER_OFS : 0) + c + PAIR_DIST * b;
    end else begin
      bit_idx = (u != 0 ? CHECK_HI : CHECK_LO) + (c - DATA_CHIPS) + CHECK_DIST * b;
    end
  endfunction : bit_idx

  // Packet k carries chip bit k of every chip on both paths
  function automatic logic [PKT_W-1:0] pkt_of(input logic [WORD_W-1:0] w, input int k);
    pkt_of = '0;
    for (int u = 0; u < 2; u++) begin
      for (int c = 0; c < CHIPS; c++) begin
        pkt_of[u*CHIPS+c] = w[bit_idx(u, c, k)];
      end
    end
  endfunction : pkt_of

  // Rebuild a word from its two packets
  function automatic logic [WORD_W-1:0] word_of(input logic [PKT_W-1:0] p1,
                                                input logic [PKT_W-1:0] p2);
    word_of = '0;
    for (int u = 0; u < 2; u++) begin
      for (int c = 0; c < CHIPS; c++) begin
        word_of[bit_idx(u, c, 0)] = p1[u*CHIPS+c];
        word_of[bit_idx(u, c, 1)] = p2[u*CHIPS+c];
      end
    end
  endfunction : word_of

  function automatic logic [BANK_W-1:0] bank_of(input logic [ADDR_W-1:0] a);
    bank_of = a[BANK_LSB +: BANK_W];
  endfunction : bank_of

  function automatic logic [WSEL_W-1:0] wsel_of(input logic [ADDR_W-1:0] a);
    wsel_of = a[WSEL_LSB +: WSEL_W];
  endfunction : wsel_of
endpackage : memref_pkg

// file: hw/memref_if.sv
// Link between the processor end and the memory end
interface memref_if;
  logic                            valid;
  logic                            write;
  logic [memref_pkg::CODE_W-1:0]   ref_code;
  logic [memref_pkg::BANK_W-1:0]   steer;
  logic [memref_pkg::ADDR_W-1:0]   addr;
  logic [memref_pkg::PKT_W-1:0]    pkt;
  logic                            resume;
  logic                            rd_valid;
  logic                            rd_ready;
  logic [memref_pkg::WORD_W-1:0]   rd_data;
  logic [memref_pkg::TAG_W-1:0]    rd_tag;

  modport memory_end (
    input  valid, write, ref_code, steer, addr, pkt, rd_ready,
    output resume, rd_valid, rd_data, rd_tag
  );
  modport processor_end (
    output valid, write, ref_code, steer, addr, pkt, rd_ready,
    input  resume, rd_valid, rd_data, rd_tag
  );
endinterface : memref_if

// file: hw/ref_fifo.sv
// First-in first-out buffer with valid and ready on both sides
module ref_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               cnt;
  } state_type;

  state_type q, d;
  logic push;
  logic pop;

  // Honest full and empty from the fill count
  assign in_ready  = (q.cnt != CW'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp        = (q.wp == LAST) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == LAST) ? '0 : q.rp + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q.wp  <= '0;
      q.rp  <= '0;
      q.cnt <= '0;
      q.mem <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : ref_fifo

// file: hw/memory_reference_port.sv
// Memory end of the reference link: input buffers, spare chip steering, storage, read return
// Summary of operation
// - Address fields: section, subsection, bank, word select
// - Four spares per stack, one per quarter
// - One flaw per quarter-stack; further flaws refused
// - Flawed chip and later chips shift upward
// - Data bits sixteen apart share a chip
// - Check bits three apart share a chip
// - Processor corrects single and same-chip double errors; the processor end here passes rd_data through uncorrected
// - Quarter-stacks serve banks n, n+4, n+10, n+14; here each bank has its own lower and upper quarter-stack
// - Sender never exceeds the receiver's buffer count
// - Sender counter rises with each valid
// - Resume pulse per advance; sender counter falls
// - Valid with control, address and packet one; packet two next
// - Control holds steering, write flag, reference code
// - Read tag rides packet one, returns with data
// - Write is two 38-bit packets, consecutive periods
// - Read returns whole 76-bit word at once
// - Six-entry input buffer sets the credit limit
// - Packet one chip bit zero of both paths, packet two chip bit one
module memory_reference_port #(
  parameter int WAW = 2  // Word select bits actually stored per bank
) (
  input  wire logic                              clk_sys,
  input  wire logic                              rst,
  memref_if.memory_end                           lnk,
  input  wire logic                              flaw_set,
  input  wire logic                              flaw_clear,
  input  wire logic [memref_pkg::BANK_W-1:0]     flaw_bank,
  input  wire logic                              flaw_upper,
  input  wire logic [memref_pkg::CHIP_W-1:0]     flaw_chip,
  output logic                                   flaw_reject,
  output logic [2*(2**memref_pkg::BANK_W)-1:0]   spare_used,
  output logic                                   overflow
);
  localparam int BANKS   = 2 ** memref_pkg::BANK_W;
  localparam int FLAWS   = 2 * BANKS;
  localparam int ENTRIES = BANKS * (2 ** WAW);
  localparam int IXW     = memref_pkg::BANK_W + WAW;
  localparam int FXW     = memref_pkg::BANK_W + 1;
  localparam int ENT_W   = 1 + memref_pkg::CODE_W + memref_pkg::ADDR_W + memref_pkg::WORD_W;
  localparam int RET_W   = memref_pkg::WORD_W + memref_pkg::TAG_W;

  typedef struct packed {
    logic [memref_pkg::ADDR_W-1:0] addr;
    logic [memref_pkg::CODE_W-1:0] code;
    logic                          write;
    logic [memref_pkg::WORD_W-1:0] word;
  } entry_type;

  typedef struct packed {
    logic                                    pend_v;
    logic [memref_pkg::CODE_W-1:0]           pend_code;
    logic [memref_pkg::ADDR_W-1:0]           pend_addr;
    logic [memref_pkg::PKT_W-1:0]            pend_p1;
    logic [FLAWS-1:0]                        flaw_en;
    logic [FLAWS-1:0][memref_pkg::CHIP_W-1:0] flaw_at;
    logic [ENTRIES-1:0][1:0][memref_pkg::PHYS_W-1:0] mem;
    logic                                    resume;
    logic                                    reject;
    logic                                    overflow;
  } state_type;

  state_type q, d;
  entry_type in_ent;
  entry_type out_ent;
  logic      in_valid;
  logic      in_ready;
  logic      out_valid;
  logic      out_ready;
  logic      ret_valid;
  logic      ret_ready;
  logic [RET_W-1:0] ret_data;
  logic [RET_W-1:0] ret_out;

  // Half-word path of a word laid out as chip pairs
  function automatic logic [memref_pkg::HALF_W-1:0] half_of(
    input logic [memref_pkg::WORD_W-1:0] w, input int u);
    half_of = '0;
    for (int c = 0; c < memref_pkg::CHIPS; c++) begin
      half_of[2*c]   = w[memref_pkg::bit_idx(u, c, 0)];
      half_of[2*c+1] = w[memref_pkg::bit_idx(u, c, 1)];
    end
  endfunction : half_of

  // Physical chip used for a logical chip under the current flaw
  function automatic int phys_chip(input int c, input logic en,
                                   input logic [memref_pkg::CHIP_W-1:0] f);
    phys_chip = (en && (c >= int'(f))) ? c + 1 : c;
  endfunction : phys_chip

  // Steer a half-word onto the 20 chips of its quarter-stack
  function automatic logic [memref_pkg::PHYS_W-1:0] to_phys(
    input logic [memref_pkg::HALF_W-1:0] h, input logic en,
    input logic [memref_pkg::CHIP_W-1:0] f);
    to_phys = '0;
    for (int c = 0; c < memref_pkg::CHIPS; c++) begin
      to_phys[2*phys_chip(c, en, f) +: 2] = h[2*c +: 2];
    end
  endfunction : to_phys

  // Gather a word back from both quarter-stacks of its bank
  function automatic logic [memref_pkg::WORD_W-1:0] gather(
    input logic [1:0][memref_pkg::PHYS_W-1:0] p, input logic [1:0] en,
    input logic [1:0][memref_pkg::CHIP_W-1:0] f);
    int pc;
    gather = '0;
    for (int u = 0; u < 2; u++) begin
      for (int c = 0; c < memref_pkg::CHIPS; c++) begin
        pc = phys_chip(c, en[u], f[u]);
        gather[memref_pkg::bit_idx(u, c, 0)] = p[u][2*pc];
        gather[memref_pkg::bit_idx(u, c, 1)] = p[u][2*pc+1];
      end
    end
  endfunction : gather

  // Storage index from bank select and the low word select bits
  function automatic logic [IXW-1:0] mem_ix(input logic [memref_pkg::ADDR_W-1:0] a);
    mem_ix = {memref_pkg::bank_of(a), a[memref_pkg::WSEL_LSB +: WAW]};
  endfunction : mem_ix

  // Six-entry input buffer ahead of the banks
  ref_fifo #(
    .WIDTH (ENT_W),
    .DEPTH (memref_pkg::IN_BUFFERS)
  ) u_input_buffer_stage (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (in_ent),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_ent)
  );

  // Read return buffer; the processor stalls it through rd_ready
  ref_fifo #(
    .WIDTH (RET_W),
    .DEPTH (memref_pkg::RET_DEPTH)
  ) u_return_buffer (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (ret_valid),
    .in_ready  (ret_ready),
    .in_data   (ret_data),
    .out_valid (lnk.rd_valid),
    .out_ready (lnk.rd_ready),
    .out_data  (ret_out)
  );

  assign lnk.rd_data = ret_out[RET_W-1 -: memref_pkg::WORD_W];
  assign lnk.rd_tag  = ret_out[memref_pkg::TAG_W-1:0];
  assign lnk.resume  = q.resume;
  assign flaw_reject = q.reject;
  assign spare_used  = q.flaw_en;
  assign overflow    = q.overflow;

  // Link capture, bank access and spare chip configuration
  always_comb begin
    logic [IXW-1:0]  ix;
    logic [FXW-1:0]  fl;
    logic [FXW-1:0]  fx;
    ix = mem_ix(out_ent.addr);
    fl = {memref_pkg::bank_of(out_ent.addr), 1'b0};
    fx = {flaw_bank, flaw_upper};
    d = q;
    d.resume = 1'b0;
    d.reject = 1'b0;
    in_valid = 1'b0;
    in_ent   = '0;
    // Second packet of a write completes the word
    if (q.pend_v) begin
      in_valid      = 1'b1;
      in_ent.write  = 1'b1;
      in_ent.code   = q.pend_code;
      in_ent.addr   = q.pend_addr;
      in_ent.word   = memref_pkg::word_of(q.pend_p1, lnk.pkt);
      d.pend_v      = 1'b0;
    end
    // Valid cycle carries control, address and the first packet
    if (lnk.valid) begin
      if (lnk.write) begin
        d.pend_v    = 1'b1;
        d.pend_code = lnk.ref_code;
        d.pend_addr = lnk.addr;
        d.pend_p1   = lnk.pkt;
      end else begin
        in_valid     = 1'b1;
        in_ent.code  = lnk.ref_code;
        in_ent.addr  = lnk.addr;
        in_ent.word  = memref_pkg::word_of(lnk.pkt, '0);
      end
    end
    // A reference past the credit limit is dropped and flagged
    if (in_valid && !in_ready) begin
      d.overflow = 1'b1;
    end
    // Head reference advances when its destination can take it
    out_ready = out_ent.write || ret_ready;
    ret_valid = out_valid && !out_ent.write;
    ret_data  = {gather(q.mem[ix], q.flaw_en[fl +: 2], q.flaw_at[fl +: 2]),
                 out_ent.word[memref_pkg::TAG_W-1:0]};
    if (out_valid && out_ready) begin
      d.resume = 1'b1;
      if (out_ent.write) begin
        for (int u = 0; u < 2; u++) begin
          d.mem[ix][u] = to_phys(half_of(out_ent.word, u), q.flaw_en[int'(fl) + u],
                                 q.flaw_at[int'(fl) + u]);
        end
      end
    end
    // One spare per quarter-stack: a second flaw is refused
    if (flaw_set) begin
      if (q.flaw_en[fx] || (int'(flaw_chip) >= memref_pkg::SPARE_CHIP)) begin
        d.reject = 1'b1;
      end else begin
        d.flaw_en[fx] = 1'b1;
        d.flaw_at[fx] = flaw_chip;
      end
    end else if (flaw_clear) begin
      d.flaw_en[fx] = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : memory_reference_port

// file: hw/processor_reference_port.sv
// Processor end of the reference link: credit counter and two-packet write sender
module processor_reference_port (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  memref_if.processor_end                    lnk,
  input  wire logic                          req_valid,
  output logic                               req_ready,
  input  wire logic                          req_write,
  input  wire logic [memref_pkg::CODE_W-1:0] req_code,
  input  wire logic [memref_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [memref_pkg::WORD_W-1:0] req_data,
  input  wire logic [memref_pkg::TAG_W-1:0]  req_tag,
  output logic                               resp_valid,
  input  wire logic                          resp_ready,
  output logic [memref_pkg::WORD_W-1:0]      resp_data,
  output logic [memref_pkg::TAG_W-1:0]       resp_tag,
  output logic [memref_pkg::CNT_W-1:0]       outstanding
);
  typedef enum logic [0:0] {
    SEND_IDLE,
    SEND_SECOND
  } send_type;

  typedef struct packed {
    send_type                      st;
    logic [memref_pkg::CNT_W-1:0]  cnt;
    logic                          valid;
    logic                          write;
    logic [memref_pkg::CODE_W-1:0] code;
    logic [memref_pkg::BANK_W-1:0] steer;
    logic [memref_pkg::ADDR_W-1:0] addr;
    logic [memref_pkg::PKT_W-1:0]  pkt;
    logic [memref_pkg::PKT_W-1:0]  p2;
  } state_type;

  localparam logic [memref_pkg::CNT_W-1:0] LIMIT = memref_pkg::CNT_W'(memref_pkg::IN_BUFFERS);

  state_type q, d;
  logic      take;

  // Stall while credits are used up or a second packet is due
  assign req_ready   = (q.st == SEND_IDLE) && (q.cnt != LIMIT);
  assign take        = req_valid && req_ready;
  assign lnk.valid    = q.valid;
  assign lnk.write    = q.write;
  assign lnk.ref_code = q.code;
  assign lnk.steer    = q.steer;
  assign lnk.addr     = q.addr;
  assign lnk.pkt      = q.pkt;
  assign lnk.rd_ready = resp_ready;
  assign resp_valid   = lnk.rd_valid;
  assign resp_data    = lnk.rd_data;
  assign resp_tag     = lnk.rd_tag;
  assign outstanding  = q.cnt;

  // Sender sequence and credit count
  always_comb begin
    d = q;
    d.valid = 1'b0;
    case (q.st)
      SEND_IDLE: begin
        if (take) begin
          d.valid = 1'b1;
          d.write = req_write;
          d.code  = req_code;
          d.steer = memref_pkg::bank_of(req_addr);
          d.addr  = req_addr;
          if (req_write) begin
            d.pkt = memref_pkg::pkt_of(req_data, 0);
            d.p2  = memref_pkg::pkt_of(req_data, 1);
            d.st  = SEND_SECOND;
          end else begin
            d.pkt = {{(memref_pkg::PKT_W - memref_pkg::TAG_W){1'b0}}, req_tag};
          end
        end
      end
      SEND_SECOND: begin
        d.pkt = q.p2;
        d.st  = SEND_IDLE;
      end
      default: begin
        d.st = SEND_IDLE;
      end
    endcase
    // Count up per valid, down per resume
    if (take && !lnk.resume) begin
      d.cnt = q.cnt + 1'b1;
    end else if (!take && lnk.resume && (q.cnt != '0)) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : processor_reference_port

// file: verif/memref_checker.sv
// Concurrent checks on the reference link between the processor end and the memory end
module memref_checker (
  input wire logic                          clk_sys,
  input wire logic                          rst,
  input wire logic                          valid,
  input wire logic                          write,
  input wire logic [memref_pkg::CODE_W-1:0] ref_code,
  input wire logic [memref_pkg::BANK_W-1:0] steer,
  input wire logic [memref_pkg::ADDR_W-1:0] addr,
  input wire logic [memref_pkg::PKT_W-1:0]  pkt,
  input wire logic                          resume,
  input wire logic                          rd_valid,
  input wire logic                          rd_ready,
  input wire logic [memref_pkg::WORD_W-1:0] rd_data,
  input wire logic [memref_pkg::TAG_W-1:0]  rd_tag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] owed_q;
  logic [3:0] owed_d;

  // References sent on the link and not yet resumed
  always_comb begin
    owed_d = owed_q + {3'h0, valid} - {3'h0, resume};
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      owed_q <= 4'h0;
    end else begin
      owed_q <= owed_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_credit_limit: assert property (owed_q <= 4'h6)
    else $error("more references outstanding than input buffers");
  a_resume_owed: assert property (resume |-> owed_q != 4'h0)
    else $error("resume without an outstanding reference");
  a_write_pair: assert property (valid && write |=> !valid)
    else $error("valid during the second packet of a write");
  a_steer_bank: assert property (valid |-> steer == addr[9:6])
    else $error("steering bits differ from the bank field");
  a_ctrl_hold: assert property (!valid |-> $stable({write, ref_code, steer, addr}))
    else $error("control or address changed without a valid");
  a_read_answer: assert property (valid && !write && owed_q == 4'h0 && !rd_valid
    |-> ##2 (resume && rd_valid && rd_tag == 16'($past(pkt, 2))))
    else $error("read word or tag late or wrong");
  a_write_resume: assert property (valid && write && owed_q == 4'h0 |-> ##3 resume)
    else $error("write resume not three cycles after valid");
  a_rd_word_hold: assert property (rd_valid && !rd_ready |=>
    rd_valid && $stable(rd_data) && $stable(rd_tag))
    else $error("read word changed while stalled");
  a_reset_quiet: assert property ($fell(rst) |-> !valid && !resume && !rd_valid)
    else $error("link active right after reset");
endmodule : memref_checker

// file: verif/memory_reference_port_bench.sv
// Bench joining both ends of the link: table cases, spare chips, credit fill and reset
module memory_reference_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic                          wr;
    logic [memref_pkg::ADDR_W-1:0] addr;
    logic [memref_pkg::WORD_W-1:0] data;
    logic [memref_pkg::TAG_W-1:0]  tag;
  } row_type;
  localparam row_type table_rows [6] = '{
    '{1'b1, 35'h0_0000_0040, 76'hA55_AAAA_5555_0F0F_F0F0, 16'h0000},
    '{1'b1, 35'h0_0000_0440, 76'h123_4567_89AB_CDEF_0246, 16'h0000},
    '{1'b0, 35'h0_0000_0040, 76'hA55_AAAA_5555_0F0F_F0F0, 16'h0001},
    '{1'b0, 35'h0_0000_0445, 76'h123_4567_89AB_CDEF_0246, 16'h0002},
    '{1'b1, 35'h0_0000_03C0, 76'hFFF_0000_FFFF_1234_8001, 16'h0000},
    '{1'b0, 35'h0_0000_03FF, 76'hFFF_0000_FFFF_1234_8001, 16'hBEEF}
  };
  logic                          clk_sys    = 1'b0;
  logic                          rst        = 1'b1;
  logic                          req_valid  = 1'b0;
  logic                          req_write  = 1'b0;
  logic [memref_pkg::CODE_W-1:0] req_code   = 4'h0;
  logic [memref_pkg::ADDR_W-1:0] req_addr   = '0;
  logic [memref_pkg::WORD_W-1:0] req_data   = '0;
  logic [memref_pkg::TAG_W-1:0]  req_tag    = '0;
  logic                          resp_ready = 1'b1;
  logic                          flaw_set   = 1'b0;
  logic                          flaw_clear = 1'b0;
  logic [memref_pkg::BANK_W-1:0] flaw_bank  = 4'h0;
  logic                          flaw_upper = 1'b0;
  logic [memref_pkg::CHIP_W-1:0] flaw_chip  = 5'h00;
  logic                          req_ready;
  logic                          resp_valid;
  logic                          flaw_reject;
  logic                          overflow;
  logic [memref_pkg::WORD_W-1:0] resp_data;
  logic [memref_pkg::TAG_W-1:0]  resp_tag;
  logic [memref_pkg::CNT_W-1:0]  outstanding;
  logic [31:0]                   spare_used;
  logic [91:0]                   got_q [$];
  int                            failures   = 0;
  int                            tests_run  = 0;
  int                            cycles     = 0;

  memref_if lnk ();
  memory_reference_port #(.WAW(2)) i_memory_reference_port (
    .clk_sys(clk_sys), .rst(rst), .lnk(lnk.memory_end), .flaw_set(flaw_set),
    .flaw_clear(flaw_clear), .flaw_bank(flaw_bank), .flaw_upper(flaw_upper),
    .flaw_chip(flaw_chip), .flaw_reject(flaw_reject), .spare_used(spare_used),
    .overflow(overflow)
  );
  processor_reference_port i_processor_reference_port (
    .clk_sys(clk_sys), .rst(rst), .lnk(lnk.processor_end), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_code(req_code), .req_addr(req_addr),
    .req_data(req_data), .req_tag(req_tag), .resp_valid(resp_valid),
    .resp_ready(resp_ready), .resp_data(resp_data), .resp_tag(resp_tag),
    .outstanding(outstanding)
  );
  memref_checker i_memref_checker (
    .clk_sys(clk_sys), .rst(rst), .valid(lnk.valid), .write(lnk.write),
    .ref_code(lnk.ref_code), .steer(lnk.steer), .addr(lnk.addr), .pkt(lnk.pkt),
    .resume(lnk.resume), .rd_valid(lnk.rd_valid), .rd_ready(lnk.rd_ready),
    .rd_data(lnk.rd_data), .rd_tag(lnk.rd_tag)
  );

  // Clock at 25 MHz
  always #20 clk_sys = ~clk_sys;

  // Captures every read word taken and cuts a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (resp_valid === 1'b1 && resp_ready === 1'b1) begin
      got_q.push_back({resp_data, resp_tag});
    end
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  // Expected packet k: data pairs sixteen apart, check pairs three apart
  function automatic logic [37:0] pkt_exp(input logic [75:0] w, input int k);
    pkt_exp = '0;
    for (int n = 0; n < 38; n++) begin
      pkt_exp[n] = (n % 19 < 16) ? w[(n / 19) * 32 + n % 19 + 16 * k]
                                 : w[(n < 19 ? 48 : 54) + n % 19 + 3 * k];
    end
  endfunction : pkt_exp

  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One request; checks what the link carries in the valid and packet-two cycles
  task automatic send(input row_type r, output bit ok);
    int n;
    ok = 1'b0;
    n = 0;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= r.wr;
    req_code  <= r.tag[3:0];
    req_addr  <= r.addr;
    req_data  <= r.data;
    req_tag   <= r.tag;
    while (!ok && n < 30) begin
      @(negedge clk_sys);
      ok = (req_ready === 1'b1);
      n++;
      @(posedge clk_sys);
    end
    req_valid <= 1'b0;
    if (ok) begin
      @(negedge clk_sys);
      chk(96'({lnk.valid, lnk.write, lnk.ref_code}), 96'({1'b1, r.wr, r.tag[3:0]}));
      if (r.wr) begin
        chk(96'(lnk.pkt), 96'(pkt_exp(r.data, 0)));
        @(negedge clk_sys);
        chk(96'({lnk.valid, lnk.pkt}), 96'({1'b0, pkt_exp(r.data, 1)}));
      end else begin
        chk(96'(lnk.pkt[15:0]), 96'(r.tag));
      end
    end
  endtask : send

  // Request, and for a read the returned word and tag
  task automatic op(input row_type r);
    bit ok;
    int n;
    send(r, ok);
    chk(96'(ok), 96'(1'b1));
    if (!r.wr) begin
      n = 0;
      while (got_q.size() == 0 && n < 40) begin
        @(negedge clk_sys);
        n++;
      end
      chk(96'(got_q.size()), 96'(1'b1));
      if (got_q.size() == 1) begin
        chk(96'(got_q.pop_front()), 96'({r.data, r.tag}));
      end
    end
  endtask : op

  task automatic flaw(input logic s, input logic [3:0] b, input logic u, input logic [4:0] c,
                      input logic rej, input logic [31:0] sp);
    @(posedge clk_sys);
    flaw_set   <= s;
    flaw_clear <= !s;
    flaw_bank  <= b;
    flaw_upper <= u;
    flaw_chip  <= c;
    @(posedge clk_sys);
    flaw_set   <= 1'b0;
    flaw_clear <= 1'b0;
    @(negedge clk_sys);
    chk(96'({flaw_reject, spare_used}), 96'({rej, sp}));
  endtask : flaw

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    bit         ok;
    logic [7:0] acc;
    acc = 8'h00;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk(96'({req_ready, outstanding, overflow, spare_used}), 96'({1'b1, 3'h0, 1'b0, 32'h0}));
    for (int i = 0; i < 6; i++) begin
      op(table_rows[i]);
    end
    flaw(1'b1, 4'h1, 1'b0, 5'h00, 1'b0, 32'h0000_0004);
    flaw(1'b1, 4'h1, 1'b1, 5'h06, 1'b0, 32'h0000_000C);
    flaw(1'b1, 4'h1, 1'b0, 5'h05, 1'b1, 32'h0000_000C);
    flaw(1'b1, 4'h2, 1'b0, 5'h13, 1'b1, 32'h0000_000C);
    op(table_rows[0]);
    op(table_rows[2]);
    flaw(1'b0, 4'h1, 1'b0, 5'h00, 1'b0, 32'h0000_0008);
    flaw(1'b1, 4'h1, 1'b0, 5'h12, 1'b0, 32'h0000_000C);
    // Return buffer and input buffers filled with the reader stalled
    @(posedge clk_sys);
    resp_ready <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      send(row_type'({1'b0, 35'h0_0000_0040, 76'h0, 16'(i)}), ok);
      acc = acc + 8'(ok);
    end
    chk(96'({acc, outstanding, req_ready, overflow}), 96'({8'h0E, 3'h6, 1'b0, 1'b0}));
    @(posedge clk_sys);
    resp_ready <= 1'b1;
    for (int n = 0; n < 200 && got_q.size() < 14; n++) begin
      @(negedge clk_sys);
    end
    chk(96'({got_q.size(), outstanding}), 96'({32'd14, 3'h0}));
    for (int i = 0; i < 14 && i < got_q.size(); i++) begin
      chk(96'(got_q[i][15:0]), 96'(i));
    end
    got_q.delete();
    // Reset in mid-run with a write in flight
    send(table_rows[0], ok);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk(96'({outstanding, lnk.valid, resp_valid, spare_used}), 96'(0));
    op(row_type'({1'b0, 35'h0_0000_0040, 76'h0, 16'h0055}));
    // Word stored unflawed, then lower chip 17 flawed: chip 18 moves down, spare reads zero
    op(row_type'({1'b1, 35'h0_0000_0080, 76'h024_0000_0000_0000_0001, 16'h0000}));
    flaw(1'b1, 4'h2, 1'b0, 5'h11, 1'b0, 32'h0000_0010);
    op(row_type'({1'b0, 35'h0_0000_0080, 76'h012_0000_0000_0000_0001, 16'h0066}));
    tally_and_finish();
  end
endmodule : memory_reference_port_bench
